// ### hdl/sabx_consts.vh
`ifndef SABX_CONSTS_VH
`define SABX_CONSTS_VH
// instruction fields
`define SABX_OP_HI 31
`define SABX_OP_LO 26
`define SABX_SRC_HI 25
`define SABX_SRC_LO 21
`define SABX_SEC_HI 20
`define SABX_SEC_LO 16
`define SABX_DST_HI 15
`define SABX_DST_LO 11
`define SABX_FN_HI 5
`define SABX_FN_LO 0
`define SABX_IMM_HI 15
`define SABX_IMM_LO 0
// primary opcodes
`define SABX_OP_SPECIAL 6'h00
`define SABX_OP_RI_CLASS 6'h01
`define SABX_OP_BEQ 6'h04
`define SABX_OP_BLEZ 6'h06
`define SABX_OP_BGTZ 6'h07
`define SABX_OP_ADDI 6'h08
`define SABX_OP_ADDIU 6'h09
`define SABX_OP_ANDI 6'h0C
// function codes
`define SABX_FN_ADD 6'h20
`define SABX_FN_ADDU 6'h21
`define SABX_FN_AND 6'h24
// register-immediate class second-field codes
`define SABX_RI_BGEZ 5'h01
`define SABX_RI_BGEZAL 5'h11
`define SABX_RI_ZERO 5'h00
// misc
`define SABX_LINK_REG 5'h1F
`define SABX_LINK_OFS 12'h008
`define SABX_SLOT_OFS 12'h004
`define SABX_PC_RESET 12'h000
`define SABX_PC_W 12
`endif

// ### hdl/sabx_regfile.v
`default_nettype none
`include "sabx_consts.vh"
// 32 x 32 general registers, entry zero hard-wired to zero
module sabx_regfile (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // read ports
   input wire [4:0] rd_a_addr,
   output wire [31:0] rd_a_data,
   input wire [4:0] rd_b_addr,
   output wire [31:0] rd_b_data,
   // write port
   input wire wr_en,
   input wire [4:0] wr_addr,
   input wire [31:0] wr_data
);
   reg [31:0] mem_q [0:31];
   integer i;

   assign rd_a_data = (rd_a_addr == 5'h00) ? 32'h00000000 :
                      mem_q[rd_a_addr]; // [RL13]
   assign rd_b_data = (rd_b_addr == 5'h00) ? 32'h00000000 :
                      mem_q[rd_b_addr]; // [RL13]

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         for (i = 0; i < 32; i = i + 1)
            mem_q[i] <= 32'h00000000;
      end
      else if (wr_en && (wr_addr != 5'h00)) // [RL13]
      begin
         mem_q[wr_addr] <= wr_data;
      end
   end
endmodule // sabx_regfile
`default_nettype wire

// ### hdl/sabx_target.v
`default_nettype none
`include "sabx_consts.vh"
// branch target: delay-slot address plus scaled offset, 12-bit wrap
module sabx_target (
   // inputs
   input wire [11:0] pc,
   input wire [15:0] offset,
   // output
   output wire [11:0] target
);
   wire [11:0] scaled;
   wire [11:0] slot;

   // only the low ten offset bits reach a 12-bit counter
   assign scaled = {offset[9:0], 2'b00};
   assign slot = pc + `SABX_SLOT_OFS;
   assign target = slot + scaled; // [RL5]
endmodule // sabx_target
`default_nettype wire

// ### hdl/sabx_core.v
`default_nettype none
`include "sabx_consts.vh"
// Overview of operation
// RL1 - add and addu write wrapped sum, no trap
// RL2 - immediate adds sign-extend, write second field
// RL3 - register and writes bitwise conjunction
// RL4 - immediate and zero-extends, upper half zero
// RL5 - target is slot address plus offset*4
// RL6 - condition now, pc changes after delay slot
// RL7 - equal branch taken on identical registers
// RL8 - non-negative branch taken when sign clear
// RL9 - linking branch always writes pc+8 link
// RL10 - software must not test link register
// RL11 - positive branch needs sign clear, nonzero
// RL12 - non-positive branch: sign set or zero
// RL13 - register zero reads zero, never written
// RL14 - fixed instruction field positions
module sabx_core (
   // clock and reset
   input wire clock,
   input wire reset_n,
   // instruction issue
   input wire instr_valid,
   input wire [31:0] instr,
   // debug read of a general register
   input wire [4:0] dbg_addr,
   // program counter and status
   output reg [11:0] pc_q,
   output reg [31:0] dbg_data_q,
   output reg taken_q,
   output reg wr_en_q,
   output reg [4:0] wr_addr_q,
   output reg [31:0] wr_data_q,
   output reg illegal_q
);
   // decoded fields
   wire [5:0] opcode;
   wire [4:0] source_reg_field;
   wire [4:0] second_reg_field;
   wire [4:0] dest_field;
   wire [5:0] func_code;
   wire [15:0] imm;
   assign opcode = instr[`SABX_OP_HI:`SABX_OP_LO]; // [RL14]
   assign source_reg_field = instr[`SABX_SRC_HI:`SABX_SRC_LO]; // [RL14]
   assign second_reg_field = instr[`SABX_SEC_HI:`SABX_SEC_LO]; // [RL14]
   assign dest_field = instr[`SABX_DST_HI:`SABX_DST_LO]; // [RL14]
   assign func_code = instr[`SABX_FN_HI:`SABX_FN_LO]; // [RL14]
   assign imm = instr[`SABX_IMM_HI:`SABX_IMM_LO]; // [RL14]

   // general register reads; port a shared with debug when idle
   wire [31:0] src_val;
   wire [31:0] sec_val;
   wire [31:0] dbg_val;
   wire [4:0] rd_b_addr;
   reg wr_en_d;
   reg [4:0] wr_addr_d;
   reg [31:0] wr_data_d;

   // a: source, b: second field; debug shares port a via mux
   assign rd_b_addr = second_reg_field;

   sabx_regfile u_regs (
      .clock(clock),
      .reset_n(reset_n),
      .rd_a_addr(instr_valid ? source_reg_field : dbg_addr),
      .rd_a_data(src_val),
      .rd_b_addr(rd_b_addr),
      .rd_b_data(sec_val),
      .wr_en(wr_en_d),
      .wr_addr(wr_addr_d),
      .wr_data(wr_data_d)
   );
   assign dbg_val = src_val;

   // branch target
   wire [11:0] target;
   sabx_target u_tgt (
      .pc(pc_q),
      .offset(imm),
      .target(target)
   );

   // sign-extended and zero-extended immediates
   wire [31:0] imm_sext;
   wire [31:0] imm_zext;
   assign imm_sext = {{16{imm[15]}}, imm}; // [RL2]
   assign imm_zext = {16'h0000, imm}; // [RL4]

   // sign and zero tests of the source register
   wire src_neg;
   wire src_zero;
   assign src_neg = src_val[31];
   assign src_zero = (src_val == 32'h00000000);

   // decode and execute
   reg cond_d;
   reg is_branch_d;
   reg illegal_d;
   wire [11:0] link_pc;
   assign link_pc = pc_q + `SABX_LINK_OFS;

   always @*
   begin
      wr_en_d = 1'b0;
      wr_addr_d = 5'h00;
      wr_data_d = 32'h00000000;
      cond_d = 1'b0;
      is_branch_d = 1'b0;
      illegal_d = 1'b0;
      if (instr_valid)
      begin
         case (opcode)
            `SABX_OP_SPECIAL:
            begin
               case (func_code)
                  `SABX_FN_ADD, `SABX_FN_ADDU:
                  begin
                     wr_en_d = 1'b1;
                     wr_addr_d = dest_field;
                     wr_data_d = src_val + sec_val; // [RL1]
                  end
                  `SABX_FN_AND:
                  begin
                     wr_en_d = 1'b1;
                     wr_addr_d = dest_field;
                     wr_data_d = src_val & sec_val; // [RL3]
                  end
                  default:
                     illegal_d = 1'b1;
               endcase
            end
            `SABX_OP_ADDI, `SABX_OP_ADDIU:
            begin
               wr_en_d = 1'b1;
               wr_addr_d = second_reg_field;
               wr_data_d = src_val + imm_sext; // [RL2]
            end
            `SABX_OP_ANDI:
            begin
               wr_en_d = 1'b1;
               wr_addr_d = second_reg_field;
               wr_data_d = src_val & imm_zext; // [RL4]
            end
            `SABX_OP_BEQ:
            begin
               is_branch_d = 1'b1;
               cond_d = (src_val == sec_val); // [RL7]
            end
            `SABX_OP_BGTZ:
            begin
               is_branch_d = 1'b1;
               cond_d = !src_neg && !src_zero; // [RL11]
            end
            `SABX_OP_BLEZ:
            begin
               is_branch_d = 1'b1;
               cond_d = src_neg || src_zero; // [RL12]
            end
            `SABX_OP_RI_CLASS:
            begin
               case (second_reg_field)
                  `SABX_RI_BGEZ:
                  begin
                     is_branch_d = 1'b1;
                     cond_d = !src_neg; // [RL8]
                  end
                  `SABX_RI_BGEZAL:
                  begin
                     // link written regardless of outcome
                     is_branch_d = 1'b1;
                     cond_d = !src_neg; // [RL9]
                     wr_en_d = 1'b1; // [RL9]
                     wr_addr_d = `SABX_LINK_REG;
                     wr_data_d = {20'h00000, link_pc}; // [RL9]
                  end
                  default:
                     illegal_d = 1'b1;
               endcase
            end
            default:
               illegal_d = 1'b1;
         endcase
      end
   end

   // pending redirect for the instruction after the branch
   reg redir_q;
   reg [11:0] redir_pc_q;

   always @(posedge clock)
   begin
      if (!reset_n)
      begin
         pc_q <= `SABX_PC_RESET;
         redir_q <= 1'b0;
         redir_pc_q <= `SABX_PC_RESET;
         taken_q <= 1'b0;
         wr_en_q <= 1'b0;
         wr_addr_q <= 5'h00;
         wr_data_q <= 32'h00000000;
         illegal_q <= 1'b0;
         dbg_data_q <= 32'h00000000;
      end
      else
      begin
         dbg_data_q <= dbg_val;
         taken_q <= 1'b0;
         wr_en_q <= wr_en_d && (wr_addr_d != 5'h00); // [RL13]
         wr_addr_q <= wr_addr_d;
         wr_data_q <= wr_data_d;
         illegal_q <= illegal_d;
         if (instr_valid)
         begin
            // delay slot: pc moves after the following instruction
            if (redir_q)
            begin
               pc_q <= redir_pc_q; // [RL6]
               redir_q <= 1'b0;
            end
            else
               pc_q <= pc_q + `SABX_SLOT_OFS;
            if (is_branch_d && cond_d)
            begin
               redir_q <= 1'b1; // [RL6]
               redir_pc_q <= target; // [RL5]
               taken_q <= 1'b1;
            end
         end
      end
   end
endmodule // sabx_core
`default_nettype wire

// ### bench/sabx_core_checker.sv
`default_nettype none
module sabx_core_checker (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // issue side
   input wire logic instr_valid,
   input wire logic [31:0] instr,
   // results
   input wire logic [11:0] pc_q,
   input wire logic taken_q,
   input wire logic wr_en_q,
   input wire logic [4:0] wr_addr_q,
   input wire logic [31:0] wr_data_q,
   input wire logic illegal_q
);
   wire logic [5:0] op = instr[31:26];
   wire logic [4:0] sec_f = instr[20:16];
   wire logic [9:0] offs = instr[9:0];
   default clocking @(posedge clock); endclocking
   default disable iff (!reset_n);
   property p_zero; wr_en_q |-> wr_addr_q != 5'h00; endproperty
   a_zero: assert property (p_zero) else $error("zero written");
   property p_andi;
      instr_valid && op == 6'h0C && sec_f != 5'h00 |=> wr_en_q &&
         wr_addr_q == $past(sec_f) && wr_data_q[31:16] == 16'h0000;
   endproperty
   a_andi: assert property (p_andi) else $error("andi result");
   property p_link;
      instr_valid && op == 6'h01 && sec_f == 5'h11 |=> wr_en_q &&
         wr_addr_q == 5'h1F && wr_data_q == {20'h0, $past(pc_q) + 12'h008};
   endproperty
   a_link: assert property (p_link) else $error("link value");
   property p_tgt;
      taken_q && instr_valid |=>
         pc_q == $past(pc_q, 2) + 12'h004 + {$past(offs, 2), 2'b00};
   endproperty
   a_tgt: assert property (p_tgt) else $error("branch target");
   property p_seq;
      instr_valid && !taken_q && $past(instr_valid) && !$past(taken_q)
         |=> pc_q == $past(pc_q) + 12'h004;
   endproperty
   a_seq: assert property (p_seq) else $error("pc step");
   property p_hold; !instr_valid && !taken_q |=> $stable(pc_q); endproperty
   a_hold: assert property (p_hold) else $error("pc moved");
   property p_ill; instr_valid && op == 6'h3F |=> illegal_q && !wr_en_q;
   endproperty
   a_ill: assert property (p_ill) else $error("illegal op");
   property p_beq;
      instr_valid && op == 6'h04 && instr[25:21] == sec_f |=> taken_q;
   endproperty
   a_beq: assert property (p_beq) else $error("equal branch");
endmodule // sabx_core_checker
bind sabx_core sabx_core_checker sabx_core_checker_i (.clock, .reset_n,
   .instr_valid, .instr, .pc_q, .taken_q, .wr_en_q, .wr_addr_q, .wr_data_q,
   .illegal_q);
`default_nettype wire

// ### bench/test_scalar_alu_branch_exec.sv
`default_nettype none
module test_scalar_alu_branch_exec;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   logic instr_valid = 1'b0;
   logic [31:0] instr = 32'h00000000;
   logic [4:0] dbg_addr = 5'h00;
   logic [11:0] pc_q;
   logic [31:0] dbg_data_q;
   logic taken_q;
   logic wr_en_q;
   logic [4:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic illegal_q;
   int fail_count = 0;
   int n_tests = 0;
   // instr, flags {write,taken,illegal}, write addr, write data, pc after
   // linking rows test r1/r2, never the link register
   logic [87:0] rows [26] = '{
      88'h2401FFFF_4_01_FFFFFFFF_004, 88'h20027FFF_4_02_00007FFF_008,
      88'h00221820_4_03_00007FFE_00C, 88'h00612021_4_04_00007FFD_010,
      88'h00222824_4_05_00007FFF_014, 88'h30268001_4_06_00008001_018,
      88'h00210021_0_00_00000000_01C, 88'h04210010_0_00_00000000_020,
      88'h1C400003_2_00_00000000_024, 88'h24070001_4_07_00000001_030,
      88'h0451FFFC_6_1F_00000038_034, 88'h24080002_4_08_00000002_024,
      88'h18200005_2_00_00000000_028, 88'h24090003_4_09_00000003_03C,
      88'h10230001_0_00_00000000_040, 88'h1045FBFF_2_00_00000000_044,
      88'h240A0004_4_0A_00000004_040, 88'h04310000_4_1F_00000048_044,
      88'h1C000001_0_00_00000000_048, 88'h18400001_0_00_00000000_04C,
      88'h10C60000_2_00_00000000_050, 88'hFC000000_1_00_00000000_050,
      88'h18000000_2_00_00000000_054, 88'h240B0005_4_0B_00000005_054,
      88'h04010001_2_00_00000000_058, 88'h00426021_4_0C_0000FFFE_05C
   };
   always #10 clock = ~clock;
   sabx_core sabx_core_i (.clock, .reset_n, .instr_valid, .instr,
      .dbg_addr, .pc_q, .dbg_data_q, .taken_q, .wr_en_q, .wr_addr_q,
      .wr_data_q, .illegal_q);
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_tests++;
      if (g !== e)
      begin
         $display("[ERR] %s exp %h got %h", nm, e, g);
         fail_count++;
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      @(negedge clock);
      dbg_addr = a;
      @(posedge clock);
      #1;
      chk("dbg_data_q", e, dbg_data_q);
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (2) @(negedge clock);
      reset_n = 1'b1;
      foreach (rows[i])
      begin
         @(negedge clock);
         instr = rows[i][87:56];
         instr_valid = 1'b1;
         @(posedge clock);
         #1;
         chk("flags", {29'h0, rows[i][54:52]},
            {29'h0, wr_en_q, taken_q, illegal_q});
         if (rows[i][54])
         begin
            chk("wr_addr_q", {27'h0, rows[i][48:44]}, {27'h0, wr_addr_q});
            chk("wr_data_q", rows[i][43:12], wr_data_q);
         end
         chk("pc_q", {20'h0, rows[i][11:0]}, {20'h0, pc_q});
      end
      $display("table done");
      @(negedge clock);
      instr_valid = 1'b0;
      rd(5'h00, 32'h00000000);
      rd(5'h1F, 32'h00000048);
      rd(5'h06, 32'h00008001);
      chk("pc_q", 32'h0000005C, {20'h0, pc_q});
      $display("idle reads done");
      @(negedge clock);
      reset_n = 1'b0;
      @(posedge clock);
      #1;
      chk("pc_q", 32'h00000000, {20'h0, pc_q});
      @(negedge clock);
      reset_n = 1'b1;
      rd(5'h01, 32'h00000000);
      $display("reset done");
      stop_test;
   end
   initial
   begin
      #5000;
      fail_count++;
      stop_test;
   end
endmodule // test_scalar_alu_branch_exec
`default_nettype wire
